// ==== drs_axil_slave.sv ====
// axi4-lite slave front end: captures writes and reads, asks the core for data
`timescale 1ns/1ps
`default_nettype none
module drs_axil_slave
    import drs_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic [7:0]  awaddr_in,
    input  wire logic        awvalid_in,
    output logic             awready_out,
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  wstrb_in,
    input  wire logic        wvalid_in,
    output logic             wready_out,
    output logic [1:0]       bresp_out,
    output logic             bvalid_out,
    input  wire logic        bready_in,
    input  wire logic [7:0]  araddr_in,
    input  wire logic        arvalid_in,
    output logic             arready_out,
    output logic [31:0]      rdata_out,
    output logic [1:0]       rresp_out,
    output logic             rvalid_out,
    input  wire logic        rready_in,
    output logic             wr_go_out,
    output logic [7:0]       wr_addr_out,
    output logic [31:0]      wr_data_out,
    output logic             rd_go_out,
    output logic [7:0]       rd_addr_out,
    input  wire logic [31:0] rd_data_in,
    input  wire logic        rd_err_in,
    input  wire logic        wr_err_in
);
    logic aw_have_reg;
    logic w_have_reg;
    logic rd_pend_reg;

    // address and data are taken independently, one outstanding write at a time
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awready_out <= 1'b1;
            wready_out  <= 1'b1;
            wr_addr_out <= 8'h00;
            wr_data_out <= 32'h0000_0000;
            wr_go_out   <= 1'b0;
            bvalid_out  <= 1'b0;
            bresp_out   <= 2'b00;
        end else begin
            wr_go_out <= 1'b0;
            if (awvalid_in && awready_out) begin
                aw_have_reg <= 1'b1;
                awready_out <= 1'b0;
                wr_addr_out <= awaddr_in;
            end
            if (wvalid_in && wready_out) begin
                w_have_reg  <= 1'b1;
                wready_out  <= 1'b0;
                // byte lane 0 carries every implemented bit
                wr_data_out <= wstrb_in[0] ? wdata_in : 32'h0000_0000;
            end
            if (aw_have_reg && w_have_reg && !bvalid_out && !wr_go_out) begin
                wr_go_out <= 1'b1;
            end
            if (wr_go_out) begin
                bvalid_out  <= 1'b1;
                bresp_out   <= wr_err_in ? DRS_RESP_SLVERR : DRS_RESP_OKAY;
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
            end
            if (bvalid_out && bready_in) begin
                bvalid_out  <= 1'b0;
                awready_out <= 1'b1;
                wready_out  <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            arready_out <= 1'b1;
            rd_go_out   <= 1'b0;
            rd_addr_out <= 8'h00;
            rd_pend_reg <= 1'b0;
            rvalid_out  <= 1'b0;
            rdata_out   <= 32'h0000_0000;
            rresp_out   <= 2'b00;
        end else begin
            rd_go_out <= 1'b0;
            if (arvalid_in && arready_out) begin
                arready_out <= 1'b0;
                rd_addr_out <= araddr_in;
                rd_go_out   <= 1'b1;
                rd_pend_reg <= 1'b1;
            end
            if (rd_pend_reg && !rd_go_out) begin
                rd_pend_reg <= 1'b0;
                rvalid_out  <= 1'b1;
                rdata_out   <= rd_data_in;
                rresp_out   <= rd_err_in ? DRS_RESP_SLVERR : DRS_RESP_OKAY;
            end
            if (rvalid_out && rready_in) begin
                rvalid_out  <= 1'b0;
                arready_out <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== drs_debug_run_status.sv ====
// debug run status: arm flag, comparator match flags, fifo count and run end
//
// Function
// RL1: comparator A flag, bit 7, cleared at run start, set on A match.
// RL2: comparator B flag, bit 6, cleared at run start, set on B match.
// RL3: with module enabled, bit 5 mirrors the capture request control bit.
// RL4: writing 1 to capture request while enabled arms the debugger.
// RL5: hardware clears the armed flag when the run finishes; a control write in the end cycle loads it from its data instead.
// RL6: run ends on fifo full (begin trace) or trigger (end trace).
// RL7: writing 0 to capture request or enable ends the run at once.
// RL8: count bits 3:0 cleared at run start, hold valid words at end.
// RL9: count is plain binary, 0000 empty up to 1000 for eight words.
// RL10: count holds its end value and never decrements during readout.
// RL11: the host tracks remaining words itself while reading the fifo.
// RL12: begin trace stores after trigger; end trace fills until trigger.
// RL13: status bit 4 reads zero; status register writes are ignored.
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "drs_defines.svh"
module drs_debug_run_status
    import drs_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic          core_clk_in,
    input  wire logic          rstn_in,
    input  wire logic [7:0]    s_axil_awaddr_in,
    input  wire logic          s_axil_awvalid_in,
    output logic               s_axil_awready_out,
    input  wire logic [31:0]   s_axil_wdata_in,
    input  wire logic [3:0]    s_axil_wstrb_in,
    input  wire logic          s_axil_wvalid_in,
    output logic               s_axil_wready_out,
    output logic [1:0]         s_axil_bresp_out,
    output logic               s_axil_bvalid_out,
    input  wire logic          s_axil_bready_in,
    input  wire logic [7:0]    s_axil_araddr_in,
    input  wire logic          s_axil_arvalid_in,
    output logic               s_axil_arready_out,
    output logic [31:0]        s_axil_rdata_out,
    output logic [1:0]         s_axil_rresp_out,
    output logic               s_axil_rvalid_out,
    input  wire logic          s_axil_rready_in,
    input  wire drs_trace_ev_t trace_ev_in,
    output logic               capture_active_out,
    output logic               store_enable_out,
    output logic               run_start_out,
    output logic               irq_out
);
    typedef enum logic [1:0] {DRS_IDLE, DRS_WAIT_TRIG, DRS_STORING} drs_state_t;

    logic        wr_go;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic        rd_go;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;
    logic        wr_err;

    logic        module_enable_reg;
    logic        capture_request_reg;
    logic        begin_trace_reg;
    logic        a_flag_reg;
    logic        b_flag_reg;
    logic [3:0]  count_reg;
    logic [2:0]  irq_stat_reg;
    logic [2:0]  irq_mask_reg;
    drs_state_t  state_reg;

    logic        ctl_write;
    logic        new_enable;
    logic        new_request;
    logic        run_start;
    logic        run_end_hw;
    logic        run_abort;
    logic        running;
    logic [2:0]  irq_events;

    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offs);
        return addr == offs;
    endfunction

    drs_axil_slave u_slave (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .awaddr_in   (s_axil_awaddr_in),
        .awvalid_in  (s_axil_awvalid_in),
        .awready_out (s_axil_awready_out),
        .wdata_in    (s_axil_wdata_in),
        .wstrb_in    (s_axil_wstrb_in),
        .wvalid_in   (s_axil_wvalid_in),
        .wready_out  (s_axil_wready_out),
        .bresp_out   (s_axil_bresp_out),
        .bvalid_out  (s_axil_bvalid_out),
        .bready_in   (s_axil_bready_in),
        .araddr_in   (s_axil_araddr_in),
        .arvalid_in  (s_axil_arvalid_in),
        .arready_out (s_axil_arready_out),
        .rdata_out   (s_axil_rdata_out),
        .rresp_out   (s_axil_rresp_out),
        .rvalid_out  (s_axil_rvalid_out),
        .rready_in   (s_axil_rready_in),
        .wr_go_out   (wr_go),
        .wr_addr_out (wr_addr),
        .wr_data_out (wr_data),
        .rd_go_out   (rd_go),
        .rd_addr_out (rd_addr),
        .rd_data_in  (rd_data),
        .rd_err_in   (rd_err),
        .wr_err_in   (wr_err)
    );

    assign running    = state_reg != DRS_IDLE;
    assign ctl_write  = wr_go && addr_is(wr_addr, `DRS_CONTROL_OFFS);
    assign new_enable = wr_data[`DRS_CTL_BIT_ENABLE];
    assign new_request = wr_data[`DRS_CTL_BIT_ARM];

    // a run starts only on a rising request while enabled
    assign run_start = ctl_write && new_enable && new_request && !capture_request_reg; // RL4
    assign run_abort = ctl_write && running && (!new_enable || !new_request); // RL7

    // begin trace ends when the fifo fills, end trace ends on the trigger
    always_comb begin
        run_end_hw = 1'b0;
        case (state_reg)
            DRS_STORING:   run_end_hw = begin_trace_reg
                                        ? (trace_ev_in.fifo_count >= 4'(FIFO_DEPTH))
                                        : trace_ev_in.trigger; // RL6
            DRS_WAIT_TRIG: run_end_hw = 1'b0;
            DRS_IDLE:      run_end_hw = 1'b0;
            default:       run_end_hw = 1'b0;
        endcase
    end

    // status writes land on a read-only word and are answered with an error
    assign wr_err = wr_go && !addr_is(wr_addr, `DRS_CONTROL_OFFS)
                    && !addr_is(wr_addr, `DRS_IRQ_STAT_OFFS)
                    && !addr_is(wr_addr, `DRS_IRQ_MASK_OFFS); // RL13

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            module_enable_reg   <= 1'b0;
            capture_request_reg <= 1'b0;
            begin_trace_reg     <= 1'b0;
        end else begin
            if (ctl_write) begin
                module_enable_reg <= new_enable;
                capture_request_reg <= new_enable && new_request; // RL4
                // trace direction is locked while a run is live
                if (!running) begin
                    begin_trace_reg <= wr_data[`DRS_CTL_BIT_BEGIN];
                end
            end else if (run_end_hw) begin
                capture_request_reg <= 1'b0; // RL5
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= DRS_IDLE;
        end else begin
            case (state_reg)
                DRS_IDLE: begin
                    if (run_start) begin
                        // end trace stores from arming on
                        state_reg <= wr_data[`DRS_CTL_BIT_BEGIN] ? DRS_WAIT_TRIG
                                                                  : DRS_STORING; // RL12
                    end
                end
                DRS_WAIT_TRIG: begin
                    if (run_abort) begin
                        state_reg <= DRS_IDLE; // RL7
                    end else if (trace_ev_in.trigger) begin
                        state_reg <= DRS_STORING; // RL12
                    end
                end
                DRS_STORING: begin
                    if (run_abort || run_end_hw) begin
                        state_reg <= DRS_IDLE; // RL6
                    end
                end
                default: state_reg <= DRS_IDLE;
            endcase
        end
    end

    // match flags live only while armed; a match in the start cycle is dropped
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            a_flag_reg <= 1'b0;
            b_flag_reg <= 1'b0;
        end else if (run_start) begin
            a_flag_reg <= 1'b0; // RL1
            b_flag_reg <= 1'b0; // RL2
        end else if (running) begin
            if (trace_ev_in.cmp_a_match) begin
                a_flag_reg <= 1'b1; // RL1
            end
            if (trace_ev_in.cmp_b_match) begin
                b_flag_reg <= 1'b1; // RL2
            end
        end
    end

    // count is captured once at run end so readout by the host never moves it
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_reg <= `DRS_CNT_EMPTY;
        end else if (run_start) begin
            count_reg <= `DRS_CNT_EMPTY; // RL8
        end else if (running && (run_end_hw || run_abort)) begin
            count_reg <= (trace_ev_in.fifo_count > `DRS_CNT_FULL)
                         ? `DRS_CNT_FULL : trace_ev_in.fifo_count; // RL9 RL10 RL11
        end
    end

    assign irq_events = {trace_ev_in.cmp_b_match && running,
                         trace_ev_in.cmp_a_match && running,
                         running && (run_end_hw || run_abort)};

    // set beats a write-one clear in the same cycle
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_stat_reg <= `DRS_IRQ_RST;
            irq_mask_reg <= `DRS_IRQ_RST;
        end else begin
            if (wr_go && addr_is(wr_addr, `DRS_IRQ_MASK_OFFS)) begin
                irq_mask_reg <= wr_data[2:0];
            end
            if (wr_go && addr_is(wr_addr, `DRS_IRQ_STAT_OFFS)) begin
                irq_stat_reg <= (irq_stat_reg & ~wr_data[2:0]) | irq_events;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_events;
            end
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (addr_is(rd_addr, `DRS_STATUS_OFFS)) begin
            rd_data[`DRS_BIT_AFLAG]          = a_flag_reg; // RL1
            rd_data[`DRS_BIT_BFLAG]          = b_flag_reg; // RL2
            rd_data[`DRS_BIT_ARMED]          = module_enable_reg && capture_request_reg; // RL3
            rd_data[`DRS_BIT_UNUSED]         = 1'b0; // RL13
            rd_data[`DRS_CNT_MSB:0]          = count_reg; // RL8
        end else if (addr_is(rd_addr, `DRS_CONTROL_OFFS)) begin
            rd_data[`DRS_CTL_BIT_ENABLE]     = module_enable_reg;
            rd_data[`DRS_CTL_BIT_ARM]        = capture_request_reg;
            rd_data[`DRS_CTL_BIT_BEGIN]      = begin_trace_reg;
        end else if (addr_is(rd_addr, `DRS_IRQ_STAT_OFFS)) begin
            rd_data[2:0] = irq_stat_reg;
        end else if (addr_is(rd_addr, `DRS_IRQ_MASK_OFFS)) begin
            rd_data[2:0] = irq_mask_reg;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            capture_active_out <= 1'b0;
            store_enable_out   <= 1'b0;
            run_start_out      <= 1'b0;
            irq_out            <= 1'b0;
        end else begin
            capture_active_out <= module_enable_reg && capture_request_reg; // RL3
            store_enable_out   <= (state_reg == DRS_STORING) && !run_end_hw && !run_abort; // RL12
            run_start_out      <= run_start;
            irq_out            <= |(irq_stat_reg & irq_mask_reg);
        end
    end
endmodule
`default_nettype wire

// ==== drs_defines.svh ====
// register offsets, field positions and reset values of the debug run status block
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH

`define DRS_STATUS_OFFS    8'h00
`define DRS_CONTROL_OFFS   8'h04
`define DRS_IRQ_STAT_OFFS  8'h08
`define DRS_IRQ_MASK_OFFS  8'h0c

`define DRS_BIT_AFLAG      7
`define DRS_BIT_BFLAG      6
`define DRS_BIT_ARMED      5
`define DRS_BIT_UNUSED     4
`define DRS_CNT_MSB        3

`define DRS_CTL_BIT_ENABLE 0
`define DRS_CTL_BIT_ARM    1
`define DRS_CTL_BIT_BEGIN  2

`define DRS_IRQ_BIT_RUNEND 0
`define DRS_IRQ_BIT_AMATCH 1
`define DRS_IRQ_BIT_BMATCH 2

`define DRS_CNT_EMPTY      4'h0
`define DRS_CNT_FULL       4'h8
`define DRS_STATUS_RST     8'h00
`define DRS_CONTROL_RST    3'h0
`define DRS_IRQ_RST        3'h0

`endif

// ==== drs_pkg.sv ====
// types shared by the debug run status block
package drs_pkg;

    typedef struct packed {
        logic       cmp_a_match;
        logic       cmp_b_match;
        logic       trigger;
        logic       fifo_write;
        logic [3:0] fifo_count;
    } drs_trace_ev_t;

    typedef enum logic [1:0] {
        DRS_RESP_OKAY   = 2'b00,
        DRS_RESP_SLVERR = 2'b10
    } drs_resp_t;

endpackage

// ==== drs_status_chk.sv ====
// port-level assertions for the debug run status block
`timescale 1ns/1ps
`default_nettype none
module drs_status_chk
    import drs_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic        core_clk_in,
    input wire logic        rstn_in,
    input wire logic [7:0]  s_axil_awaddr_in,
    input wire logic        s_axil_awvalid_in,
    input wire logic        s_axil_awready_out,
    input wire logic [31:0] s_axil_wdata_in,
    input wire logic [3:0]  s_axil_wstrb_in,
    input wire logic        s_axil_wvalid_in,
    input wire logic        s_axil_wready_out,
    input wire logic [1:0]  s_axil_bresp_out,
    input wire logic        s_axil_bvalid_out,
    input wire logic [7:0]  s_axil_araddr_in,
    input wire logic        s_axil_arvalid_in,
    input wire logic        s_axil_arready_out,
    input wire logic [31:0] s_axil_rdata_out,
    input wire logic [1:0]  s_axil_rresp_out,
    input wire logic        s_axil_rvalid_out,
    input wire logic        capture_active_out,
    input wire logic        run_start_out,
    input wire logic        irq_out
);
    logic [7:0] wa_reg;
    logic [7:0] ra_reg;
    logic [1:0] ctl_reg;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wa_reg  <= 8'h00;
            ra_reg  <= 8'h00;
            ctl_reg <= 2'h0;
        end else begin
            if (s_axil_awvalid_in && s_axil_awready_out)
                wa_reg <= s_axil_awaddr_in;
            if (s_axil_wvalid_in && s_axil_wready_out)
                ctl_reg <= s_axil_wstrb_in[0] ? s_axil_wdata_in[1:0] : 2'h0;
            if (s_axil_arvalid_in && s_axil_arready_out)
                ra_reg <= s_axil_araddr_in;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    property p_arm;
        $rose(s_axil_bvalid_out) && wa_reg == 8'h04 && ctl_reg == 2'h3 |=> capture_active_out;
    endproperty
    a_arm: assert property (p_arm) else $error("arm lost");
    property p_abort;
        $rose(s_axil_bvalid_out) && wa_reg == 8'h04 && ctl_reg != 2'h3 |=> !capture_active_out;
    endproperty
    a_abort: assert property (p_abort) else $error("abort lost");
    // the start pulse leads the registered armed output by one cycle
    property p_start;
        run_start_out |-> !capture_active_out ##1 capture_active_out;
    endproperty
    a_start: assert property (p_start) else $error("start not fresh");
    property p_pulse;
        run_start_out |=> !run_start_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("start too long");
    property p_st_zero;
        s_axil_rvalid_out && ra_reg == 8'h00 |-> s_axil_rdata_out[31:8] == 24'h0
            && !s_axil_rdata_out[4] && s_axil_rresp_out == DRS_RESP_OKAY;
    endproperty
    a_st_zero: assert property (p_st_zero) else $error("unused bits set");
    property p_cnt;
        s_axil_rvalid_out && ra_reg == 8'h00 |-> s_axil_rdata_out[3:0] <= FIFO_DEPTH;
    endproperty
    a_cnt: assert property (p_cnt) else $error("count too high");
    property p_st_wr;
        $rose(s_axil_bvalid_out) && wa_reg == 8'h00 |-> s_axil_bresp_out == DRS_RESP_SLVERR;
    endproperty
    a_st_wr: assert property (p_st_wr) else $error("status write taken");
    property p_mirror;
        s_axil_rvalid_out && ra_reg == 8'h00 && $stable(capture_active_out)
            && $past(capture_active_out, 2) == capture_active_out
            && $past(capture_active_out, 3) == capture_active_out
            |-> s_axil_rdata_out[5] == capture_active_out;
    endproperty
    a_mirror: assert property (p_mirror) else $error("armed bit wrong");
    property p_busy;
        s_axil_bvalid_out |-> !s_axil_awready_out && !s_axil_wready_out;
    endproperty
    a_busy: assert property (p_busy) else $error("write taken while busy");
    c_start: cover property (run_start_out);
    c_end: cover property ($fell(capture_active_out));
    c_irq: cover property (irq_out);
endmodule
`default_nettype wire

// ==== drs_trace_host.sv ====
// trace source and debug host model: events and fifo fill level
`timescale 1ns/1ps
`default_nettype none
module drs_trace_host
    import drs_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input  wire logic   core_clk_in,
    input  wire logic   rstn_in,
    input  wire logic   store_enable_in,
    input  wire logic   run_start_in,
    input  wire logic   feed_in,
    input  wire logic   drain_in,
    input  wire logic   cmp_a_in,
    input  wire logic   cmp_b_in,
    input  wire logic   trig_in,
    output var drs_trace_ev_t trace_ev_out
);
    logic [3:0] words_reg;
    // the fifo wraps in end trace, so its fill level saturates at the depth
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            words_reg <= 4'h0;
        else if (run_start_in)
            words_reg <= 4'h0;
        else if (feed_in && store_enable_in && words_reg < 4'(DEPTH))
            words_reg <= words_reg + 4'h1;
        else if (drain_in && words_reg != 4'h0)
            words_reg <= words_reg - 4'h1;
    end
    assign trace_ev_out = {cmp_a_in, cmp_b_in, trig_in, feed_in & store_enable_in, words_reg};
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the debug run status block
`timescale 1ns/1ps
`default_nettype none
module tb
    import drs_pkg::*;
;
    logic          core_clk_in, rstn_in, awvalid, wvalid, bready, arvalid, rready;
    logic          awready, wready, bvalid, arready, rvalid, feed, drain, cmp_a, cmp_b, trig;
    logic          cap_act, store_en, run_start, irq;
    logic [7:0]    awaddr, araddr;
    logic [31:0]   wdata, rdata;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp;
    drs_trace_ev_t trace_ev;
    logic [65:0]   rq[$];
    logic [1:0]    bq[$];
    int            fail_count, total_checks, n, k;
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    drs_debug_run_status #(.FIFO_DEPTH(8)) dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .s_axil_awaddr_in(awaddr), .s_axil_awvalid_in(awvalid), .s_axil_awready_out(awready),
        .s_axil_wdata_in(wdata), .s_axil_wstrb_in(wstrb), .s_axil_wvalid_in(wvalid),
        .s_axil_wready_out(wready), .s_axil_bresp_out(bresp), .s_axil_bvalid_out(bvalid),
        .s_axil_bready_in(bready), .s_axil_araddr_in(araddr), .s_axil_arvalid_in(arvalid),
        .s_axil_arready_out(arready), .s_axil_rdata_out(rdata), .s_axil_rresp_out(rresp),
        .s_axil_rvalid_out(rvalid), .s_axil_rready_in(rready), .trace_ev_in(trace_ev),
        .capture_active_out(cap_act), .store_enable_out(store_en),
        .run_start_out(run_start), .irq_out(irq));
    drs_trace_host #(.DEPTH(8)) u_host (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .store_enable_in(store_en), .run_start_in(run_start), .feed_in(feed),
        .drain_in(drain), .cmp_a_in(cmp_a), .cmp_b_in(cmp_b), .trig_in(trig),
        .trace_ev_out(trace_ev));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // results are judged at the handshake edge, oldest expectation first
    always @(posedge core_clk_in) begin
        if (rvalid && rready) begin
            chk("rdata", rq[0][31:0], rdata & rq[0][63:32]);
            chk("rresp", {30'h0, rq[0][65:64]}, {30'h0, rresp});
            void'(rq.pop_front());
        end
        if (bvalid && bready) begin
            chk("bresp", {30'h0, bq[0]}, {30'h0, bresp});
            void'(bq.pop_front());
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input drs_resp_t r);
        bq.push_back(r);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input drs_resp_t r);
        rq.push_back({r, m, e});
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
    endtask
    task automatic wait_on(input logic sel, input logic v);
        for (n = 0; n < 50 && (sel ? store_en : cap_act) !== v; n++)
            @(posedge core_clk_in);
        chk(sel ? "store_enable" : "capture_active", {31'h0, v},
            {31'h0, (sel ? store_en : cap_act)});
    endtask
    task automatic pulse(input int w, input int c);
        if (w == 0) feed <= 1'b1; else if (w == 1) drain <= 1'b1;
        else if (w == 2) cmp_a <= 1'b1; else if (w == 3) cmp_b <= 1'b1; else trig <= 1'b1;
        repeat (c) @(posedge core_clk_in);
        {feed, drain, cmp_a, cmp_b, trig} <= 5'h00;
        @(posedge core_clk_in);
    endtask
    function automatic logic [31:0] st(input logic a, b, m, input logic [3:0] c);
        return {24'h0, a, b, m, 1'b0, c};
    endfunction
    initial begin
        {rstn_in, awvalid, wvalid, arvalid, feed, drain, cmp_a, cmp_b, trig} = 9'h000;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {bready, rready} = 2'h3;
        fail_count = 0;
        total_checks = 0;
        void'($urandom(13477));
        repeat (10) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        @(posedge core_clk_in);
        for (k = 0; k < 4; k++)
            rd(8'(k * 4), 32'h0, 32'hffffffff, DRS_RESP_OKAY);
        rd(8'h10, 32'h0, 32'h0, DRS_RESP_SLVERR);
        wr(8'h00, 32'hff, 4'hf, DRS_RESP_SLVERR);
        rd(8'h00, 32'h0, 32'hffffffff, DRS_RESP_OKAY);
        $display("test reset_and_map done");
        k = 1 + $urandom % 6;
        wr(8'h0c, 32'h7, 4'hf, DRS_RESP_OKAY);
        wr(8'h04, 32'h3, {3'($urandom), 1'b1}, DRS_RESP_OKAY);
        wait_on(0, 1'b1);
        rd(8'h00, st(0, 0, 1, 4'h0), 32'hff, DRS_RESP_OKAY);
        wait_on(1, 1'b1);
        pulse(0, k);
        pulse(2, 1);
        pulse(4, 1);
        wait_on(0, 1'b0);
        rd(8'h00, st(1, 0, 0, 4'(k)), 32'hff, DRS_RESP_OKAY);
        pulse(1, k);
        rd(8'h00, st(1, 0, 0, 4'(k)), 32'hff, DRS_RESP_OKAY);
        rd(8'h08, 32'h3, 32'h7, DRS_RESP_OKAY);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h08, 32'h7, 4'hf, DRS_RESP_OKAY);
        rd(8'h08, 32'h0, 32'h7, DRS_RESP_OKAY);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test end_trace done");
        wr(8'h0c, 32'h0, 4'hf, DRS_RESP_OKAY);
        wr(8'h04, 32'h7, 4'hf, DRS_RESP_OKAY);
        wait_on(0, 1'b1);
        pulse(0, 3);
        rd(8'h00, st(0, 0, 1, 4'h0), 32'hff, DRS_RESP_OKAY);
        pulse(3, 1);
        pulse(4, 1);
        wait_on(1, 1'b1);
        pulse(0, 12);
        wait_on(0, 1'b0);
        rd(8'h00, st(0, 1, 0, 4'h8), 32'hff, DRS_RESP_OKAY);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h0c, 32'h1, 4'hf, DRS_RESP_OKAY);
        rd(8'h08, 32'h5, 32'h7, DRS_RESP_OKAY);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h08, 32'h7, 4'hf, DRS_RESP_OKAY);
        $display("test begin_trace done");
        wr(8'h04, 32'h3, 4'hf, DRS_RESP_OKAY);
        wait_on(1, 1'b1);
        pulse(0, 2);
        wr(8'h04, 32'h3, 4'h0, DRS_RESP_OKAY);
        wait_on(0, 1'b0);
        rd(8'h00, st(0, 0, 0, 4'h0), 32'he0, DRS_RESP_OKAY);
        wr(8'h04, 32'h3, 4'hf, DRS_RESP_OKAY);
        wait_on(0, 1'b1);
        wr(8'h04, 32'h2, 4'hf, DRS_RESP_OKAY);
        wait_on(0, 1'b0);
        wr(8'h04, 32'h0, 4'hf, DRS_RESP_OKAY);
        $display("test abort done");
        test_done;
    end
    initial begin
        repeat (20000) @(posedge core_clk_in);
        fail_count++;
        test_done;
    end
endmodule
// checker ports carry the same names as the block's ports
bind drs_debug_run_status drs_status_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);
`default_nettype wire
